// ==== shared/edst_pkg.sv ====
/*
  constants and carrier types for the energy-detect status and threshold block.
  assumes a single 20 MHz clock domain and a management register port that
  presents a 16-bit register with separate read and write strobes.
*/
// Operation
// - A read-only power-state bit reads 1 while energy detect is powered up and 0 while powered down.
// - The power-state bit has no meaning while energy detect is disabled.
// - An error-threshold-met flag sets when the error count reaches its threshold, clears on read, and drives nothing else.
// - A data-threshold-met flag sets once the data count equals or exceeds its threshold and clears on read.
// - A 4-bit read-write error threshold field resets to 0001.
// - A 4-bit read-write data threshold field resets to 0001.
// - The event counters restart after about two seconds with no data event.
// - Counting and flags work only while the enable bit, reset to 0, is set.
// - With automatic wake enabled, power-up starts as soon as the data threshold is reached.
// - A self-clearing manual bit forces a power-state change when written to 1 while the enable bit is already set.
package edst_pkg;
  // ****************************************************************
  // bit positions in energy_detect_control
  // ****************************************************************
  localparam int BIT_ENABLE     = 15;
  localparam int BIT_AUTO_UP    = 14;
  localparam int BIT_AUTO_DOWN  = 13;
  localparam int BIT_MANUAL     = 12;
  localparam int BIT_BURST_DIS  = 11;
  localparam int BIT_PWR_STATE  = 10;
  localparam int BIT_ERR_MET    = 9;
  localparam int BIT_DATA_MET   = 8;
  localparam int ERR_THR_LSB    = 4;
  localparam int DATA_THR_LSB   = 0;
  localparam int THR_W          = 4;
  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [3:0]  THR_RESET      = 4'h1;
  localparam logic        ENABLE_RESET   = 1'b0;
  localparam logic        AUTO_UP_RESET  = 1'b1;
  localparam logic        AUTO_DN_RESET  = 1'b1;
  localparam logic        BURST_RESET    = 1'b0;
  localparam longint      CLK_HZ         = 20_000_000;
  localparam longint      QUIET_MS       = 2000;
  localparam longint      QUIET_CYCLES   = (QUIET_MS * CLK_HZ) / 1000;

  typedef struct packed {
    logic data_event;
    logic error_event;
  } edst_events_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } edst_reg_req_type;
endpackage : edst_pkg

// ==== rtl/edst_counter.sv ====
/*
  saturating event counter with threshold compare.
  assumes events and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module edst_counter #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  input  wire logic         inc,
  input  wire logic [W-1:0] thr,
  output var  logic         met
);
  import edst_pkg::*;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // refused at elaboration: a zero-width counter cannot hold any count
  if (W < 1) begin : g_bad_width
    $error("counter width must be positive");
  end

  always_comb begin
    cnt_d = cnt_q;
    if (clr) begin
      cnt_d = '0;
    end else if (inc && cnt_q != {W{1'b1}}) begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // met in the cycle the counter reaches or passes the threshold
  assign met = inc && !clr && (cnt_d >= thr);
endmodule : edst_counter
`default_nettype wire

// ==== rtl/edst_core.sv ====
/*
  energy-detect status and threshold logic with its control register.
  assumes event inputs arrive asynchronously from the receiver and are
  synchronised here; register access is a 16-bit read/write port.
*/
`timescale 1ns/1ps
`default_nettype none
module edst_core #(
  parameter longint QUIET_LIMIT = edst_pkg::QUIET_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire edst_pkg::edst_events_type  line_events,
  input  wire edst_pkg::edst_reg_req_type reg_req,
  output var  logic [15:0]                reg_rdata,
  output var  logic                       ed_power_state_bit,
  output var  logic                       power_up_start,
  output var  logic                       power_down_start
);
  import edst_pkg::*;

  // the quiet timer is 32 bits wide and needs at least two states
  if (QUIET_LIMIT < 2 || QUIET_LIMIT > 64'h0000_0001_0000_0000) begin : g_bad_quiet
    $error("quiet limit out of range");
  end

  // ****************************************************************
  // reset release and input synchronisers
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  edst_events_type ev_meta_q;
  edst_events_type ev_sync_q;
  edst_events_type ev_prev_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_meta_q <= '0;
      ev_sync_q <= '0;
      ev_prev_q <= '0;
    end else begin
      ev_meta_q <= line_events;
      ev_sync_q <= ev_meta_q;
      ev_prev_q <= ev_sync_q;
    end
  end

  logic data_pulse;
  logic err_pulse;
  assign data_pulse = ev_sync_q.data_event & ~ev_prev_q.data_event;
  assign err_pulse  = ev_sync_q.error_event & ~ev_prev_q.error_event;

  // ****************************************************************
  // control register
  // ****************************************************************
  logic             enable_q, enable_d;
  logic             auto_up_q, auto_up_d;
  logic             auto_dn_q, auto_dn_d;
  logic             burst_q, burst_d;
  logic             manual;
  logic [THR_W-1:0] err_thr_q, err_thr_d;
  logic [THR_W-1:0] data_thr_q, data_thr_d;

  always_comb begin
    enable_d   = enable_q;
    auto_up_d  = auto_up_q;
    auto_dn_d  = auto_dn_q;
    burst_d    = burst_q;
    err_thr_d  = err_thr_q;
    data_thr_d = data_thr_q;
    if (reg_req.wr) begin
      enable_d   = reg_req.wdata[BIT_ENABLE];
      auto_up_d  = reg_req.wdata[BIT_AUTO_UP];
      auto_dn_d  = reg_req.wdata[BIT_AUTO_DOWN];
      burst_d    = reg_req.wdata[BIT_BURST_DIS];
      err_thr_d  = reg_req.wdata[ERR_THR_LSB +: THR_W];
      data_thr_d = reg_req.wdata[DATA_THR_LSB +: THR_W];
    end
  end

  // the manual bit is never stored, so it reads back 0 (self-clearing)
  assign manual = reg_req.wr & reg_req.wdata[BIT_MANUAL];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q   <= ENABLE_RESET;
      auto_up_q  <= AUTO_UP_RESET;
      auto_dn_q  <= AUTO_DN_RESET;
      burst_q    <= BURST_RESET;
      err_thr_q  <= THR_RESET;
      data_thr_q <= THR_RESET;
    end else begin
      enable_q   <= enable_d;
      auto_up_q  <= auto_up_d;
      auto_dn_q  <= auto_dn_d;
      burst_q    <= burst_d;
      err_thr_q  <= err_thr_d;
      data_thr_q <= data_thr_d;
    end
  end

  // ****************************************************************
  // quiet timer and counters
  // ****************************************************************
  logic [31:0] quiet_q, quiet_d;
  logic        quiet_expired;
  logic        cnt_clr;
  logic        data_met;
  logic        err_met;
  logic        data_inc;
  logic        err_inc;

  assign quiet_expired = (quiet_q == 32'(QUIET_LIMIT - 1));
  // counting only runs while enabled; timeout restarts both counters
  assign cnt_clr  = !enable_q || quiet_expired;
  assign data_inc = enable_q & data_pulse;
  assign err_inc  = enable_q & err_pulse;

  always_comb begin
    quiet_d = quiet_q + 32'h0000_0001;
    if (!enable_q || data_pulse || quiet_expired) begin
      quiet_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_q <= 32'h0000_0000;
    end else begin
      quiet_q <= quiet_d;
    end
  end

  edst_counter #(.W(THR_W)) u_data_cnt (
    .clk   (clk),
    .rst_n (rst_n),
    .clr   (cnt_clr),
    .inc   (data_inc),
    .thr   (data_thr_q),
    .met   (data_met)
  );

  edst_counter #(.W(THR_W)) u_err_cnt (
    .clk   (clk),
    .rst_n (rst_n),
    .clr   (cnt_clr),
    .inc   (err_inc),
    .thr   (err_thr_q),
    .met   (err_met)
  );

  // ****************************************************************
  // flags, power state, read data
  // ****************************************************************
  logic        data_flag_q, data_flag_d;
  logic        err_flag_q, err_flag_d;
  logic        pwr_q, pwr_d;
  logic        up_q, up_d;
  logic        dn_q, dn_d;
  logic [15:0] rdata_q, rdata_d;

  always_comb begin
    // set wins over the clearing read
    data_flag_d = data_met | (data_flag_q & ~reg_req.rd);
    err_flag_d  = err_met | (err_flag_q & ~reg_req.rd);
    pwr_d = pwr_q;
    up_d  = 1'b0;
    dn_d  = 1'b0;
    if (enable_q) begin
      if (manual) begin
        pwr_d = ~pwr_q;
        up_d  = ~pwr_q;
        dn_d  = pwr_q;
      end else if (!pwr_q && auto_up_q && data_met) begin
        pwr_d = 1'b1;
        up_d  = 1'b1;
      end else if (pwr_q && auto_dn_q && quiet_expired) begin
        pwr_d = 1'b0;
        dn_d  = 1'b1;
      end
    end
    rdata_d = rdata_q;
    if (reg_req.rd) begin
      rdata_d = {enable_q, auto_up_q, auto_dn_q, 1'b0, burst_q, pwr_q,
                 err_flag_q, data_flag_q, err_thr_q, data_thr_q};
    end
  end

  // error flag is informational: nothing else reads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_flag_q <= 1'b0;
      err_flag_q  <= 1'b0;
      pwr_q       <= 1'b0;
      up_q        <= 1'b0;
      dn_q        <= 1'b0;
      rdata_q     <= 16'h0000;
    end else begin
      data_flag_q <= data_flag_d;
      err_flag_q  <= err_flag_d;
      pwr_q       <= pwr_d;
      up_q        <= up_d;
      dn_q        <= dn_d;
      rdata_q     <= rdata_d;
    end
  end

  assign reg_rdata          = rdata_q;
  assign ed_power_state_bit = pwr_q;
  assign power_up_start     = up_q;
  assign power_down_start   = dn_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_data_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    data_met |=> data_flag_q) else $error("data flag not set");
  a_err_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    err_met |=> err_flag_q) else $error("error flag not set");
  a_flag_read_clr: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_req.rd && !data_met) |=> !data_flag_q) else $error("flag not cleared");
  a_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_req.rd && data_met) |=> data_flag_q) else $error("flag lost on read");
  a_flags_off_dis: assert property (@(posedge clk) disable iff (!rst_n)
    (!enable_q && !$past(enable_q)) |-> !data_met && !err_met) else $error("count while off");
  a_auto_wake: assert property (@(posedge clk) disable iff (!rst_n)
    (enable_q && !pwr_q && auto_up_q && data_met && !manual) |=> pwr_q && up_q)
    else $error("auto wake missed");
  a_manual_flip: assert property (@(posedge clk) disable iff (!rst_n)
    (enable_q && manual) |=> pwr_q != $past(pwr_q)) else $error("manual toggle missed");
  a_quiet_restart: assert property (@(posedge clk) disable iff (!rst_n)
    quiet_expired |=> quiet_q == 32'h0000_0000) else $error("timer not restarted");
  a_pwr_output: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 ed_power_state_bit == $past(pwr_d)) else $error("power bit mismatch");
  a_thr_write: assert property (@(posedge clk) disable iff (!rst_n)
    reg_req.wr |=> data_thr_q == $past(reg_req.wdata[3:0])) else $error("threshold write lost");
  a_rd_state: assert property (@(posedge clk) disable iff (!rst_n)
    reg_req.rd |=> reg_rdata[BIT_PWR_STATE] == $past(pwr_q)) else $error("read state wrong");

  c_data_met: cover property (@(posedge clk) disable iff (!rst_n) data_met);
  c_err_met: cover property (@(posedge clk) disable iff (!rst_n) err_met);
  c_wake: cover property (@(posedge clk) disable iff (!rst_n) up_q);
  c_sleep: cover property (@(posedge clk) disable iff (!rst_n) dn_q);
  c_read_race: cover property (@(posedge clk) disable iff (!rst_n) reg_req.rd && data_met);
endmodule : edst_core
`default_nettype wire

// ==== sim/edst_line_model.sv ====
/*
  line-side model: turns requests from the bench into data and error
  energy events on the receiver outputs.
  assumes one clock shared with the block; events are plain levels.
*/
`timescale 1ns/1ps
`default_nettype none
module edst_line_model (
  input  wire logic                     clk,
  output var  edst_pkg::edst_events_type line_events
);
  import edst_pkg::*;
  // ****************************************************************
  // event pulses
  // ****************************************************************
  initial line_events = '0;
  // high for two cycles, then a long low gap so the edge detector re-arms
  task automatic pulses(input logic is_err, input int n);
    repeat (n) begin
      @(posedge clk);
      if (is_err) begin
        line_events.error_event <= 1'b1;
      end else begin
        line_events.data_event <= 1'b1;
      end
      repeat (2) @(posedge clk);
      line_events <= '0;
      repeat (6) @(posedge clk);
    end
  endtask : pulses
endmodule : edst_line_model
`default_nettype wire

// ==== sim/edst_tb_top.sv ====
/*
  self-checking bench for the energy-detect status and threshold block.
  assumes the line model drives events; quiet limit shortened to 200.
*/
`timescale 1ns/1ps
`default_nettype none
module edst_tb_top;
  import edst_pkg::*;
  // ****************************************************************
  // clock, reset and instances
  // ****************************************************************
  localparam longint QL = 200;
  logic             clk       = 1'b0;
  logic             resetn    = 1'b0;
  edst_reg_req_type req       = '0;
  edst_events_type  ev;
  logic [15:0]      rdata;
  logic             pwr;
  logic             up;
  logic             dn;
  logic [15:0]      v;
  int               failures  = 0;
  int               cmp_count = 0;
  int               up_cnt    = 0;
  int               dn_cnt    = 0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (up === 1'b1) up_cnt <= up_cnt + 1;
    if (dn === 1'b1) dn_cnt <= dn_cnt + 1;
  end
  edst_core #(.QUIET_LIMIT(QL)) u_dut (
    .clk               (clk),
    .resetn            (resetn),
    .line_events       (ev),
    .reg_req           (req),
    .reg_rdata         (rdata),
    .ed_power_state_bit(pwr),
    .power_up_start    (up),
    .power_down_start  (dn)
  );
  edst_line_model u_line (
    .clk        (clk),
    .line_events(ev)
  );
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] d);
    @(posedge clk);
    req.wr    <= 1'b1;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(output logic [15:0] d);
    @(posedge clk);
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  task automatic chk_pwr(input logic e);
    chk({15'h0000, pwr}, {15'h0000, e});
  endtask : chk_pwr
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(v);
    chk(v, 16'h6011);
    chk_pwr(1'b0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_off;
    u_line.pulses(1'b0, 2);
    rd(v);
    chk(v, 16'h6011);
    chk(16'(up_cnt), 16'h0000);
    $display("test disabled done");
  endtask : t_off
  // data threshold 2, error threshold 3, auto up and down on
  task automatic t_data;
    wr(16'he032);
    u_line.pulses(1'b0, 1);
    rd(v);
    chk(v, 16'he032);
    u_line.pulses(1'b0, 1);
    chk(16'(up_cnt), 16'h0001);
    chk_pwr(1'b1);
    rd(v);
    chk(v, 16'he532);
    rd(v);
    chk(v, 16'he432);
    $display("test data done");
  endtask : t_data
  task automatic t_err;
    u_line.pulses(1'b1, 2);
    rd(v);
    chk(v, 16'he432);
    u_line.pulses(1'b1, 1);
    rd(v);
    chk(v, 16'he632);
    chk(16'(dn_cnt), 16'h0000);
    chk(16'(up_cnt), 16'h0001);
    rd(v);
    chk(v, 16'he432);
    $display("test error done");
  endtask : t_err
  // a single data event after the quiet spell must not reach threshold 2
  task automatic t_quiet;
    repeat (QL + 60) @(posedge clk);
    chk(16'(dn_cnt), 16'h0001);
    chk_pwr(1'b0);
    u_line.pulses(1'b0, 1);
    rd(v);
    chk(v, 16'he032);
    $display("test quiet done");
  endtask : t_quiet
  task automatic t_man;
    wr(16'hf032);
    repeat (2) @(posedge clk);
    chk_pwr(1'b1);
    rd(v);
    chk(v, 16'he432);
    wr(16'hf032);
    repeat (2) @(posedge clk);
    chk_pwr(1'b0);
    $display("test manual done");
  endtask : t_man
  // data threshold 1; the clearing read lands on the edge that counts the event
  task automatic t_race;
    wr(16'he031);
    fork
      u_line.pulses(1'b0, 1);
      begin
        repeat (3) @(posedge clk);
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk(rdata, 16'he031);
      end
    join
    rd(v);
    chk(v, 16'he531);
    $display("test race done");
  endtask : t_race
  // ****************************************************************
  // sequence and verdict
  // ****************************************************************
  task automatic print_verdict;
    $display("counts: compares=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_off();
    t_data();
    t_err();
    t_quiet();
    t_man();
    t_race();
    print_verdict();
  end
  // the tests need well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule : edst_tb_top
`default_nettype wire
